// File: core/bipcs_pkg.sv
package bipcs_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] PORT_CONTROL_STATUS_OFS = 8'h28;
    localparam logic [7:0] WRITE_STATUS_OFS = 8'h2c;
    localparam logic [7:0] FORCE_SETUP_OFS = 8'h30;
    localparam logic [7:0] LINK_STATUS_OFS = 8'h34;

    // port control field positions
    localparam int BURST_HOLD_ENABLE_BIT = 17;
    localparam int FORCE_BIT = 16;
    localparam int MULTICAST_EN_BIT = 15;
    localparam int BROADCAST_EN_BIT = 14;
    localparam int STOP_EN_BIT = 13;
    localparam int RESERVED_EN_BIT = 12;
    localparam int IDENT_EN_BIT = 11;
    localparam int INVALIDATE_EN_BIT = 10;
    localparam int WRITE_INVALIDATE_EN_BIT = 9;
    localparam int USER_CSR_EN_BIT = 8;
    localparam int CHIP_CSR_EN_BIT = 7;
    localparam int INTERRUPT_EN_BIT = 6;
    localparam int IP_INTERRUPT_EN_BIT = 5;
    localparam int PIPELINE_NEXT_EN_BIT = 4;
    localparam int RETRY_TIMEOUT_EN_BIT = 3;
    localparam logic [31:0] PORT_CONTROL_WRITE_MASK = 32'h0003_fff8;
    localparam logic [31:0] PORT_CONTROL_RESET = 32'h0000_0000;

    // force setup register fields
    localparam int FORCE_DEST_LSB = 0;
    localparam int FORCE_CMD_BIT = 16;
    localparam logic [15:0] FORCE_DEST_RESET = 16'h0000;

    // received command codes
    typedef enum logic [3:0] {
        BIPCS_CMD_NONE = 4'h0,
        BIPCS_CMD_READ = 4'h1,
        BIPCS_CMD_WRITE = 4'h2,
        BIPCS_CMD_STOP = 4'h3,
        BIPCS_CMD_RESERVED = 4'h4,
        BIPCS_CMD_BROADCAST = 4'h5,
        BIPCS_CMD_INVALIDATE = 4'h6,
        BIPCS_CMD_INTERRUPT = 4'h7,
        BIPCS_CMD_INTERPROCESSOR_INTERRUPT_CMD = 4'h8
    } bipcs_cmd_e;

    // select codes to the user port
    localparam logic [2:0] SELECT_NONE = 3'h0;
    localparam logic [2:0] SELECT_USER_CSR_READ = 3'h1;
    localparam logic [2:0] SELECT_USER_CSR_WRITE = 3'h2;
    localparam logic [2:0] SELECT_STOP = 3'h3;
    localparam logic [2:0] SELECT_RESERVED = 3'h4;

    // response codes
    localparam logic [1:0] RESP_NONE = 2'h0;
    localparam logic [1:0] RESP_ACK = 2'h1;
    localparam logic [1:0] RESP_NACK = 2'h2;

    // event code for failed forced command
    localparam logic [4:0] EVENT_NONE = 5'h00;
    localparam logic [4:0] FORCED_CMD_NACK_EVENT_CODE = 5'h1d;

    // force sequencer states
    typedef enum logic [2:0] {
        BIPCS_FS_IDLE = 3'b001,
        BIPCS_FS_ARB = 3'b010,
        BIPCS_FS_SEND = 3'b100
    } bipcs_force_e;
endpackage

// File: core/bipcs_port_control.sv
// Contract
// - burst enable holds no-arb after next win
// - master abort clears burst state only
// - force bit sends forced command
// - force bit self-clears after transmission
// - failed force gives event and nack flag
// - broadcast and invalidate commands get nack
// - stop enable selects port on stop
// - reserved enable selects port on reserved
// - reserved commands nacked, even with the enable set
// - interrupt commands get nack
// - interprocessor interrupt commands ignored entirely
// - user csr enable selects on read/write
// - write status register has no effect
module bipcs_port_control
    import bipcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    // bus arbitration and transfer
    input wire logic arb_won_in,
    input wire logic port_master_abort_input_in,
    output logic no_arbitration_line_out,
    output logic force_arb_request_out,
    output logic force_cmd_valid_out,
    output logic force_cmd_is_stop_out,
    output logic [15:0] force_dest_out,
    input wire logic force_done_in,
    input wire logic force_fail_in,
    output logic [4:0] forced_cmd_nack_event_code_out,
    output logic multiresponder_nack_flag_out,
    // received commands
    input wire logic rx_cmd_valid_in,
    input wire logic [3:0] rx_cmd_in,
    input wire logic rx_to_this_node_in,
    input wire logic rx_user_csr_space_in,
    output logic port_select_out,
    output logic [2:0] select_code_out,
    output logic [1:0] response_out,
    // side enables
    output logic retry_timeout_event_enable_out,
    output logic chip_csr_enable_out
);

    // whole block state, registered in one place
    typedef struct packed {
        // software-visible register contents
        logic [31:0] ctrl;
        logic [15:0] force_dest;
        logic force_is_stop;
        logic multiresponder_nack_flag;

        // bus-side sequencing
        bipcs_force_e fstate;
        logic burst_active;
        logic force_req;
        logic force_valid;

        // one-cycle outputs, cleared every cycle by default
        logic [4:0] event_code;
        logic [31:0] rdata;
        logic sel;
        logic [2:0] sc;
        logic [1:0] resp;
    } bipcs_state_s;

    bipcs_state_s st;
    bipcs_state_s next_st;
    bipcs_cmd_e rx_cmd;
    logic rx_for_us;
    logic force_finish;

    // out-of-range codes fall to the decode default and get no answer
    assign rx_cmd = bipcs_cmd_e'(rx_cmd_in);

    // a command counts only when valid and aimed at this node
    assign rx_for_us = rx_cmd_valid_in && rx_to_this_node_in;

    // success and failure both close the forced transfer
    assign force_finish = force_done_in || force_fail_in;

    // next state: register port, burst hold, force sequencer, command decode
    always_comb begin
        // hold everything by default
        next_st = st;

        // pulse outputs fall back to idle every cycle
        next_st.event_code = EVENT_NONE;
        next_st.rdata = 32'h0000_0000;
        next_st.sel = 1'b0;
        next_st.sc = SELECT_NONE;
        next_st.resp = RESP_NONE;

        // register writes; write status space accepts and drops data
        if (reg_write_in) begin
            unique case (reg_addr_in)
                PORT_CONTROL_STATUS_OFS: begin
                    // spare bits are dropped here, so they always read zero
                    next_st.ctrl = reg_wdata_in & PORT_CONTROL_WRITE_MASK;
                end

                FORCE_SETUP_OFS: begin
                    // taken at the next force, so set this up first
                    next_st.force_dest = reg_wdata_in[FORCE_DEST_LSB +: 16];
                    next_st.force_is_stop = reg_wdata_in[FORCE_CMD_BIT];
                end

                LINK_STATUS_OFS: begin
                    // write one to clear; a same-cycle failure still sets below
                    if (reg_wdata_in[0]) begin
                        next_st.multiresponder_nack_flag = 1'b0;
                    end
                end

                default: begin
                    // write status and unmapped space swallow the data
                    next_st.ctrl = st.ctrl;
                end
            endcase
        end

        // read data stands one cycle after the strobe
        if (reg_read_in) begin
            unique case (reg_addr_in)
                PORT_CONTROL_STATUS_OFS: begin
                    next_st.rdata = st.ctrl & PORT_CONTROL_WRITE_MASK;
                end

                FORCE_SETUP_OFS: begin
                    // stop flag sits just above the destination
                    next_st.rdata = {15'h0000, st.force_is_stop, st.force_dest};
                end

                LINK_STATUS_OFS: begin
                    next_st.rdata = {29'h0000_0000, st.burst_active, st.force_req, st.multiresponder_nack_flag};
                end

                default: begin
                    // write status and unmapped space read as zero
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end

        // burst hold: starts on a win, dropped by abort or clearing the enable
        if (!next_st.ctrl[BURST_HOLD_ENABLE_BIT]) begin
            // the new control value counts, so a clearing write ends it at once
            next_st.burst_active = 1'b0;
        end else if (port_master_abort_input_in) begin
            // only the hold drops; the enable bit stays for the next win
            next_st.burst_active = 1'b0;
        end else if (arb_won_in) begin
            // any win, forced or not, starts or keeps the hold
            next_st.burst_active = 1'b1;
        end

        // force sequencer: arbitrate, send, then self-clear the force bit
        unique case (st.fstate)
            BIPCS_FS_IDLE: begin
                // software sets the force bit; the sequencer clears it when done
                if (st.ctrl[FORCE_BIT]) begin
                    next_st.fstate = BIPCS_FS_ARB;
                    next_st.force_req = 1'b1;
                end
            end

            BIPCS_FS_ARB: begin
                // request stands until a won arbitration
                if (arb_won_in) begin
                    next_st.fstate = BIPCS_FS_SEND;
                    next_st.force_req = 1'b0;
                    next_st.force_valid = 1'b1;
                end
            end

            BIPCS_FS_SEND: begin
                // valid stands until the far side reports the outcome
                if (force_finish) begin
                    next_st.fstate = BIPCS_FS_IDLE;
                    next_st.force_valid = 1'b0;
                    next_st.ctrl[FORCE_BIT] = 1'b0;
                    if (force_fail_in) begin
                        // event code for one cycle, flag until software clears it
                        next_st.event_code = FORCED_CMD_NACK_EVENT_CODE;
                        next_st.multiresponder_nack_flag = 1'b1;
                    end
                end
            end

            default: begin
                // illegal code: back to idle without sending
                next_st.fstate = BIPCS_FS_IDLE;
                next_st.force_req = 1'b0;
                next_st.force_valid = 1'b0;
            end
        endcase

        // received command decode towards the user port
        if (rx_for_us) begin
            unique case (rx_cmd)
                BIPCS_CMD_STOP: begin
                    // with stop enable clear the command is left unanswered
                    if (st.ctrl[STOP_EN_BIT]) begin
                        next_st.sel = 1'b1;
                        next_st.sc = SELECT_STOP;
                        next_st.resp = RESP_ACK;
                    end
                end

                BIPCS_CMD_RESERVED: begin
                    // the select still fires but the bus answer stays nack
                    if (st.ctrl[RESERVED_EN_BIT]) begin
                        next_st.sel = 1'b1;
                        next_st.sc = SELECT_RESERVED;
                    end
                    next_st.resp = RESP_NACK;
                end

                BIPCS_CMD_READ, BIPCS_CMD_WRITE: begin
                    // outside user space or disabled: no select and no answer
                    if (st.ctrl[USER_CSR_EN_BIT] && rx_user_csr_space_in) begin
                        next_st.sel = 1'b1;
                        next_st.sc = (rx_cmd == BIPCS_CMD_READ) ? SELECT_USER_CSR_READ : SELECT_USER_CSR_WRITE;
                        next_st.resp = RESP_ACK;
                    end
                end

                BIPCS_CMD_BROADCAST, BIPCS_CMD_INVALIDATE: begin
                    // refused outright, whatever their enables hold
                    next_st.resp = RESP_NACK;
                end

                BIPCS_CMD_INTERRUPT: begin
                    next_st.resp = RESP_NACK;
                end

                BIPCS_CMD_INTERPROCESSOR_INTERRUPT_CMD: begin
                    // no select and no answer at all
                    next_st.resp = RESP_NONE;
                end

                default: begin
                    next_st.resp = RESP_NONE;
                end
            endcase
        end
    end

    // state register; every output is one of these flops
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // software-visible registers
            st.ctrl <= PORT_CONTROL_RESET;
            st.force_dest <= FORCE_DEST_RESET;
            st.force_is_stop <= 1'b0;
            st.multiresponder_nack_flag <= 1'b0;
            // sequencing
            st.fstate <= BIPCS_FS_IDLE;
            st.burst_active <= 1'b0;
            st.force_req <= 1'b0;
            st.force_valid <= 1'b0;
            // one-cycle outputs
            st.event_code <= EVENT_NONE;
            st.rdata <= 32'h0000_0000;
            st.sel <= 1'b0;
            st.sc <= SELECT_NONE;
            st.resp <= RESP_NONE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign reg_rdata_out = st.rdata;

    // burst hold and forced transfer towards the bus
    assign no_arbitration_line_out = st.burst_active;
    assign force_arb_request_out = st.force_req;
    assign force_cmd_valid_out = st.force_valid;
    assign force_cmd_is_stop_out = st.force_is_stop;
    assign force_dest_out = st.force_dest;

    // failure report: pulse code plus sticky flag
    assign forced_cmd_nack_event_code_out = st.event_code;
    assign multiresponder_nack_flag_out = st.multiresponder_nack_flag;

    // select and answer for received commands
    assign port_select_out = st.sel;
    assign select_code_out = st.sc;
    assign response_out = st.resp;

    // control bits used elsewhere in the chip
    assign retry_timeout_event_enable_out = st.ctrl[RETRY_TIMEOUT_EN_BIT];
    assign chip_csr_enable_out = st.ctrl[CHIP_CSR_EN_BIT];

endmodule

// File: bench/bipcs_port_control_sva.sv
module bipcs_port_control_sva
    import bipcs_pkg::*;
(
    // clock, reset, register port
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    // arbitration and force
    input wire logic arb_won_in,
    input wire logic port_master_abort_input_in,
    input wire logic no_arbitration_line_out,
    input wire logic force_arb_request_out,
    input wire logic force_cmd_valid_out,
    input wire logic force_done_in,
    input wire logic force_fail_in,
    input wire logic [4:0] forced_cmd_nack_event_code_out,
    input wire logic multiresponder_nack_flag_out,
    // received commands
    input wire logic rx_cmd_valid_in,
    input wire logic [3:0] rx_cmd_in,
    input wire logic rx_to_this_node_in,
    input wire logic port_select_out,
    input wire logic [1:0] response_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // force steps: win while requesting, then the failure report
    sequence s_force_win;
        force_arb_request_out && arb_won_in;
    endsequence
    sequence s_fail_report;
        forced_cmd_nack_event_code_out == FORCED_CMD_NACK_EVENT_CODE && multiresponder_nack_flag_out
        ##1 forced_cmd_nack_event_code_out == EVENT_NONE;
    endsequence
    a_ctl_zero_bits: assert property (
        $past(reg_read_in) && $past(reg_addr_in) == PORT_CONTROL_STATUS_OFS
        |-> reg_rdata_out[31:18] == 14'h0 && reg_rdata_out[2:0] == 3'h0) else $error("control spare bits set");
    a_write_status_inert: assert property (
        $past(reg_read_in) && $past(reg_addr_in) == WRITE_STATUS_OFS |-> reg_rdata_out == 32'h0)
        else $error("write status not zero");
    a_hold_cause: assert property (
        $rose(no_arbitration_line_out) |-> $past(arb_won_in)) else $error("hold without a win");
    a_abort_clears: assert property (
        port_master_abort_input_in |=> !no_arbitration_line_out) else $error("hold kept after abort");
    a_force_send: assert property (
        s_force_win |=> force_cmd_valid_out && !force_arb_request_out) else $error("forced command not sent");
    a_force_ends: assert property (
        force_cmd_valid_out && (force_done_in || force_fail_in) |=> !force_cmd_valid_out)
        else $error("forced command did not end");
    a_fail_event: assert property (
        force_cmd_valid_out && force_fail_in |=> s_fail_report) else $error("failure not reported");
    a_nack_cmds: assert property (
        rx_cmd_valid_in && rx_to_this_node_in && rx_cmd_in inside {BIPCS_CMD_BROADCAST, BIPCS_CMD_INVALIDATE,
        BIPCS_CMD_INTERRUPT, BIPCS_CMD_RESERVED} |=> response_out == RESP_NACK) else $error("nack missing");
    a_interprocessor_interrupt_cmd_mute: assert property (
        rx_cmd_valid_in && rx_cmd_in == BIPCS_CMD_INTERPROCESSOR_INTERRUPT_CMD |=> !port_select_out && response_out == RESP_NONE)
        else $error("answered an ip interrupt");
endmodule

bind bipcs_port_control bipcs_port_control_sva chk_u (.*);

// File: bench/bipcs_bus_node.sv
module bipcs_bus_node (
    // clock, reset and bench controls
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic req_in,
    input wire logic fail_in,
    // design side
    input wire logic force_arb_request_out,
    input wire logic force_cmd_valid_out,
    output logic arb_won_in,
    output logic force_done_in,
    output logic force_fail_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    wire logic want_arb = (req_in || force_arb_request_out) && !arb_won_in;
    wire logic want_end = force_cmd_valid_out && !force_done_in && !force_fail_in;
    wire logic hit = (want_arb || want_end) && cnt == {fail_in, 2'h1};
    // failures answer slowly, so the design must wait them out
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt <= 3'h0;
            arb_won_in <= 1'b0;
            force_done_in <= 1'b0;
            force_fail_in <= 1'b0;
        end else begin
            cnt <= (hit || !(want_arb || want_end)) ? 3'h0 : cnt + 3'h1;
            arb_won_in <= want_arb && hit;
            force_done_in <= want_end && hit && !fail_in;
            force_fail_in <= want_end && hit && fail_in;
        end
    end
endmodule

// File: bench/bipcs_port_control_bench.sv
module bipcs_port_control_bench
    import bipcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0, rstn_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic rx_cmd_valid_in = 1'b0, rx_to_this_node_in = 1'b0, rx_user_csr_space_in = 1'b0;
    logic port_master_abort_input_in = 1'b0, req_in = 1'b0, fail_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h0;
    logic [31:0] reg_wdata_in = 32'h0, seed = 32'ha2e35b16, r, k, reg_rdata_out;
    logic [3:0] rx_cmd_in = 4'h0;
    logic arb_won_in, force_done_in, force_fail_in, no_arbitration_line_out, force_arb_request_out;
    logic force_cmd_valid_out, force_cmd_is_stop_out, multiresponder_nack_flag_out, port_select_out;
    logic retry_timeout_event_enable_out, chip_csr_enable_out;
    logic [15:0] force_dest_out;
    logic [4:0] forced_cmd_nack_event_code_out;
    logic [2:0] select_code_out;
    logic [1:0] response_out;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    // design and the far-side node, joined by matching names
    bipcs_port_control dut_u (.*);
    bipcs_bus_node node_u (.*);
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected {select, code, response} for one received command
    function automatic logic [5:0] exp_cmd(input logic [3:0] c, input logic u, input logic [31:0] e);
        case (c)
            BIPCS_CMD_STOP: return e[13] ? {1'b1, SELECT_STOP, RESP_ACK} : 6'h0;
            BIPCS_CMD_READ: return (u && e[8]) ? {1'b1, SELECT_USER_CSR_READ, RESP_ACK} : 6'h0;
            BIPCS_CMD_WRITE: return (u && e[8]) ? {1'b1, SELECT_USER_CSR_WRITE, RESP_ACK} : 6'h0;
            BIPCS_CMD_RESERVED: return {e[12], e[12] ? SELECT_RESERVED : SELECT_NONE, RESP_NACK};
            BIPCS_CMD_BROADCAST, BIPCS_CMD_INVALIDATE, BIPCS_CMD_INTERRUPT: return {4'h0, RESP_NACK};
            default: return 6'h0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        @(negedge core_clk_in);
        chk(reg_rdata_out, e);
    endtask
    // bounded wait on hold line (s=1) or forced valid (s=0)
    task automatic wait_for(input int s, input logic v);
        @(negedge core_clk_in);
        repeat (50) if ((s ? no_arbitration_line_out : force_cmd_valid_out) !== v) @(negedge core_clk_in);
        chk(32'(s ? no_arbitration_line_out : force_cmd_valid_out), 32'(v));
    endtask
    task automatic test_done();
        $display("TB: mismatches=%0d compares=%0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #20 core_clk_in = ~core_clk_in;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        rstn_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        rd(PORT_CONTROL_STATUS_OFS, PORT_CONTROL_RESET);
        wr(PORT_CONTROL_STATUS_OFS, 32'hfffc_0007);
        wr(WRITE_STATUS_OFS, 32'hffff_ffff);
        rd(PORT_CONTROL_STATUS_OFS, 32'h0);
        rd(WRITE_STATUS_OFS, 32'h0);
        rd(8'h3c, 32'h0);
        // bring-up order of the port adapter
        wr(PORT_CONTROL_STATUS_OFS, 32'h0000_0008);
        wr(PORT_CONTROL_STATUS_OFS, 32'h0000_2008);
        wr(PORT_CONTROL_STATUS_OFS, 32'h0000_2108);
        @(negedge core_clk_in);
        chk(32'({retry_timeout_event_enable_out, chip_csr_enable_out}), 32'h2);
        // every command code first, then random traffic
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            k = 32'h0108 | (r & 32'h3000) | (i == 3 ? 32'h2000 : 32'h0);
            wr(PORT_CONTROL_STATUS_OFS, k);
            @(posedge core_clk_in);
            rx_cmd_valid_in <= 1'b1;
            rx_cmd_in <= i < 9 ? 4'(i) : 4'(r[7:4] % 4'h9);
            rx_to_this_node_in <= i < 9 || r[8];
            rx_user_csr_space_in <= r[9];
            @(posedge core_clk_in);
            rx_cmd_valid_in <= 1'b0;
            @(negedge core_clk_in);
            k = rx_to_this_node_in ? 32'(exp_cmd(rx_cmd_in, rx_user_csr_space_in, k)) : 32'h0;
            chk(32'({port_select_out, select_code_out, response_out}), k);
        end
        // forced command, good then failing
        for (int f = 0; f < 2; f++) begin
            r = rnd() & 32'h0001_ffff;
            fail_in <= f[0];
            wr(FORCE_SETUP_OFS, r);
            wr(PORT_CONTROL_STATUS_OFS, 32'h0001_2108);
            wait_for(0, 1'b1);
            chk(32'({force_cmd_is_stop_out, force_dest_out}), r);
            wait_for(0, 1'b0);
            chk(32'({forced_cmd_nack_event_code_out, multiresponder_nack_flag_out}), f ? 32'h3b : 32'h0);
            rd(PORT_CONTROL_STATUS_OFS, 32'h2108);
        end
        rd(FORCE_SETUP_OFS, r);
        rd(LINK_STATUS_OFS, 32'h1);
        wr(LINK_STATUS_OFS, 32'h1);
        rd(LINK_STATUS_OFS, 32'h0);
        // burst hold, aborted mid-burst and resumed
        fail_in <= 1'b0;
        wr(PORT_CONTROL_STATUS_OFS, 32'h0002_2108);
        req_in <= 1'b1;
        wait_for(1, 1'b1);
        @(posedge core_clk_in);
        port_master_abort_input_in <= 1'b1;
        @(posedge core_clk_in);
        port_master_abort_input_in <= 1'b0;
        @(negedge core_clk_in);
        chk(32'(no_arbitration_line_out), 32'h0);
        wait_for(1, 1'b1);
        rd(PORT_CONTROL_STATUS_OFS, 32'h0002_2108);
        rd(LINK_STATUS_OFS, 32'h4);
        wr(PORT_CONTROL_STATUS_OFS, 32'h2108);
        req_in <= 1'b0;
        wait_for(1, 1'b0);
        test_done();
    end
endmodule
